// file: design/dpsp_pkg.sv
// Shared constants, types and encodings of the dual-port parity-checked memory block.
package dpsp_pkg;

    // Array geometry: 32K words of eight data bits plus one parity bit.
    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int DEPTH  = 32768;

    // Register bus geometry and register byte offsets.
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] REG_MASK   = 8'h08;
    localparam logic [APB_AW-1:0] REG_LAST   = 8'h0C;

    // Control register fields and reset value.
    localparam int CTRL_CHECK_EN = 0;
    localparam int CTRL_W        = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 1'h1;

    // Event bits shared by the status and mask registers.
    localparam int EV_FAULT = 0;
    localparam int EV_WRITE = 1;
    localparam int EV_CLASH = 2;
    localparam int EV_W     = 3;
    localparam logic [EV_W-1:0] STATUS_RST = 3'h0;
    localparam logic [EV_W-1:0] MASK_RST   = 3'h0;

    // Cycle kinds decoded at each rising edge of the memory clock.
    typedef enum logic [2:0] {
        MODE_IDLE   = 3'b000,
        MODE_READ   = 3'b001,
        MODE_WRITE  = 3'b010,
        MODE_STREAM = 3'b011,
        MODE_NOP    = 3'b100
    } dpsp_mode_t;

    // Synchronous and asynchronous cycle controls, all active low.
    typedef struct packed {
        logic write_n;
        logic proc_input_enable_n;
        logic sys_input_enable_n;
        logic proc_output_enable_n;
        logic sys_output_enable_n;
    } dpsp_ctl_t;

    // One memory word: parity line above the eight data lines.
    typedef struct packed {
        logic       par;
        logic [7:0] data;
    } dpsp_word_t;

endpackage : dpsp_pkg

// file: design/dpsp_top.sv
// Dual-port parity-checked memory: cycle decode, array, port latches, checker and APB registers.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module dpsp_top
    import dpsp_pkg::*;
(
    // System clock and reset.
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    // Memory clock and synchronous and asynchronous memory controls.
    input  wire logic              k_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              select_low_active_n_i,
    input  wire logic              select_high_active_i,
    input  wire dpsp_ctl_t         ctl_i,
    // Processor data port, split into input, output and enable.
    input  wire dpsp_word_t        proc_data_lines_i,
    output      dpsp_word_t        proc_data_lines_o,
    output      logic              proc_data_lines_oe_n_o,
    // System data port, split into input, output and enable.
    input  wire dpsp_word_t        sys_data_lines_i,
    output      dpsp_word_t        sys_data_lines_o,
    output      logic              sys_data_lines_oe_n_o,
    // Open-drain parity fault pin.
    output      logic              parity_fault_n_o,
    output      logic              parity_fault_n_oe_n_o,
    // APB slave.
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [APB_AW-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output      logic [31:0]       prdata_o,
    output      logic              pready_o,
    output      logic              pslverr_o,
    // Interrupt.
    output      logic              irq_o
);

    // Decodes the cycle kind from the latched select and the sampled controls.
    function automatic dpsp_mode_t decode_mode(input logic sel, input dpsp_ctl_t c);
        dpsp_mode_t m;
        m = MODE_NOP;
        if (!sel) begin
            m = MODE_IDLE;
        end else if (c.proc_input_enable_n ^ c.sys_input_enable_n) begin
            m = c.write_n ? MODE_STREAM : MODE_WRITE;
        end else if (c.write_n && c.proc_input_enable_n) begin
            if (!(c.proc_output_enable_n && c.sys_output_enable_n)) begin
                m = MODE_READ;
            end
        end
        return m;
    endfunction : decode_mode

    // Decodes an APB byte address into a known register.
    function automatic logic reg_hit(input logic [APB_AW-1:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_MASK) || (a == REG_LAST);
    endfunction : reg_hit

    logic [DATA_W-1:0] mem [DEPTH];

    logic              k_q_reg,       k_q_next;
    logic              sel_reg,       sel_next;
    logic [ADDR_W-1:0] addr_reg,      addr_next;
    dpsp_word_t        proc_lat_reg,  proc_lat_next;
    dpsp_word_t        sys_lat_reg,   sys_lat_next;
    logic              drv_p_reg,     drv_p_next;
    logic              drv_s_reg,     drv_s_next;
    logic              p_oe_n_reg,    p_oe_n_next;
    logic              s_oe_n_reg,    s_oe_n_next;
    logic              pend_reg,      pend_next;
    logic              fault_n_reg,   fault_n_next;
    logic [CTRL_W-1:0] ctrl_reg,      ctrl_next;
    logic [EV_W-1:0]   status_reg,    status_next;
    logic [EV_W-1:0]   mask_reg,      mask_next;
    logic [ADDR_W-1:0] last_reg,      last_next;
    logic [31:0]       prdata_reg,    prdata_next;
    logic              pready_reg,    pready_next;
    logic              pslverr_reg,   pslverr_next;
    logic              irq_reg,       irq_next;

    logic              k_rise;
    logic              k_fall;
    dpsp_mode_t        mode_now;
    dpsp_word_t        bus_now;
    logic              bus_valid;
    logic              mem_we;
    logic [EV_W-1:0]   events;
    logic              apb_wr;

    // The memory clock is a plain synchronous input; edges are found by comparing with
    // the previous sample, so the whole block stays in the system clock domain.
    assign k_rise = k_i & ~k_q_reg;
    assign k_fall = ~k_i & k_q_reg;
    assign mode_now = decode_mode(sel_reg, ctl_i);
    assign mem_we = k_rise && (mode_now == MODE_WRITE);
    assign apb_wr = psel_i && penable_i && pready_reg && pwrite_i;

    // Internal bus: the array on a read, the enabled input port on a write or stream, zero otherwise.
    always_comb begin
        bus_now   = '0;
        bus_valid = 1'b0;
        case (mode_now)
            MODE_READ: begin
                bus_now   = dpsp_word_t'(mem[addr_reg]);
                bus_valid = 1'b1;
            end
            MODE_WRITE, MODE_STREAM: begin
                bus_now   = ctl_i.proc_input_enable_n ? sys_data_lines_i : proc_data_lines_i;
                bus_valid = 1'b1;
            end
            default: begin
                bus_now   = '0;
                bus_valid = 1'b0;
            end
        endcase
    end

    // Next state of the memory side: captures, latches, drivers and parity checker.
    always_comb begin
        k_q_next      = k_i;
        sel_next      = sel_reg;
        addr_next     = addr_reg;
        proc_lat_next = proc_lat_reg;
        sys_lat_next  = sys_lat_reg;
        drv_p_next    = drv_p_reg;
        drv_s_next    = drv_s_reg;
        pend_next     = pend_reg;
        fault_n_next  = fault_n_reg;
        last_next     = last_reg;
        events        = '0;
        if (k_fall) begin
            sel_next  = ~select_low_active_n_i & select_high_active_i;
            addr_next = addr_i;
        end
        if (k_rise) begin
            // Latches follow the bus only at the rising edge, modelling transparency while high.
            drv_p_next = 1'b0;
            drv_s_next = 1'b0;
            case (mode_now)
                MODE_READ: begin
                    proc_lat_next = bus_now;
                    sys_lat_next  = bus_now;
                    drv_p_next    = 1'b1;
                    drv_s_next    = 1'b1;
                end
                MODE_WRITE, MODE_STREAM: begin
                    if (ctl_i.proc_input_enable_n) begin
                        proc_lat_next = bus_now;
                        drv_p_next    = 1'b1;
                    end else begin
                        sys_lat_next  = bus_now;
                        drv_s_next    = 1'b1;
                    end
                end
                default: begin
                    drv_p_next = 1'b0;
                    drv_s_next = 1'b0;
                end
            endcase
            // Odd parity over nine bits; an even count is a fault.
            pend_next    = bus_valid && ctrl_reg[CTRL_CHECK_EN] && !(^bus_now);
            // The flag shows the check of the previous cycle.
            fault_n_next = !(sel_reg && pend_reg);
            events[EV_FAULT] = sel_reg && pend_reg;
            events[EV_WRITE] = (mode_now == MODE_WRITE);
            if (bus_valid) begin
                last_next = addr_reg;
            end
        end
        // Input and output enabled together on one port is a contention the far side caused.
        events[EV_CLASH] = sel_reg && ((!ctl_i.proc_input_enable_n && !ctl_i.proc_output_enable_n)
                           || (!ctl_i.sys_input_enable_n && !ctl_i.sys_output_enable_n));
        // Output enables are asynchronous at the pins, so they follow every system cycle.
        p_oe_n_next = !(drv_p_reg && !ctl_i.proc_output_enable_n && sel_reg);
        s_oe_n_next = !(drv_s_reg && !ctl_i.sys_output_enable_n && sel_reg);
    end

    // Registers of the memory side; reset leaves both ports floating and the flag released.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            k_q_reg      <= 1'b1; // Matches K parked high, so release shows no false rise.
            sel_reg      <= 1'b0;
            addr_reg     <= '0;
            proc_lat_reg <= '0;
            sys_lat_reg  <= '0;
            drv_p_reg    <= 1'b0;
            drv_s_reg    <= 1'b0;
            p_oe_n_reg   <= 1'b1;
            s_oe_n_reg   <= 1'b1;
            pend_reg     <= 1'b0;
            fault_n_reg  <= 1'b1;
            last_reg     <= '0;
        end else begin
            k_q_reg      <= k_q_next;
            sel_reg      <= sel_next;
            addr_reg     <= addr_next;
            proc_lat_reg <= proc_lat_next;
            sys_lat_reg  <= sys_lat_next;
            drv_p_reg    <= drv_p_next;
            drv_s_reg    <= drv_s_next;
            p_oe_n_reg   <= p_oe_n_next;
            s_oe_n_reg   <= s_oe_n_next;
            pend_reg     <= pend_next;
            fault_n_reg  <= fault_n_next;
            last_reg     <= last_next;
        end
    end

    // The array has no reset; its contents are undefined until written.
    always_ff @(posedge clk_sys_i) begin
        if (mem_we) begin
            mem[addr_reg] <= bus_now;
        end
    end

    // Next state of the APB slave, with write-one-to-clear status where a new event wins.
    always_comb begin
        ctrl_next    = ctrl_reg;
        mask_next    = mask_reg;
        status_next  = status_reg;
        prdata_next  = prdata_reg;
        pready_next  = psel_i && !penable_i;
        pslverr_next = psel_i && !penable_i && !reg_hit(paddr_i);
        if (apb_wr && paddr_i == REG_CTRL) begin
            ctrl_next = pwdata_i[CTRL_W-1:0];
        end
        if (apb_wr && paddr_i == REG_MASK) begin
            mask_next = pwdata_i[EV_W-1:0];
        end
        if (apb_wr && paddr_i == REG_STATUS) begin
            status_next = status_reg & ~pwdata_i[EV_W-1:0];
        end
        status_next = status_next | events;
        if (psel_i && !penable_i) begin
            case (paddr_i)
                REG_CTRL:   prdata_next = {{(32-CTRL_W){1'b0}}, ctrl_reg};
                REG_STATUS: prdata_next = {{(32-EV_W){1'b0}}, status_reg};
                REG_MASK:   prdata_next = {{(32-EV_W){1'b0}}, mask_reg};
                REG_LAST:   prdata_next = {{(32-ADDR_W){1'b0}}, last_reg};
                default:    prdata_next = '0;
            endcase
        end
        irq_next = |(status_reg & mask_reg);
    end

    // Registers of the APB slave.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_reg    <= CTRL_RST;
            mask_reg    <= MASK_RST;
            status_reg  <= STATUS_RST;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            mask_reg    <= mask_next;
            status_reg  <= status_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
        end
    end

    // Outputs, each straight from a flip-flop; the fault pin only ever drives low.
    assign proc_data_lines_o      = proc_lat_reg;
    assign sys_data_lines_o       = sys_lat_reg;
    assign proc_data_lines_oe_n_o = p_oe_n_reg;
    assign sys_data_lines_oe_n_o  = s_oe_n_reg;
    assign parity_fault_n_o       = fault_n_reg;
    assign parity_fault_n_oe_n_o  = fault_n_reg;
    assign prdata_o               = prdata_reg;
    assign pready_o               = pready_reg;
    assign pslverr_o              = pslverr_reg;
    assign irq_o                  = irq_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    a_fault_one_late: assert property (k_rise && sel_reg && pend_reg |=> ##0 !parity_fault_n_oe_n_o)
        else $error("fault flag not pulled one clock after a failed check");
    a_nop_no_access: assert property (k_rise && !ctl_i.proc_input_enable_n
        && !ctl_i.sys_input_enable_n |-> !mem_we && !bus_valid)
        else $error("array accessed in a no-operation cycle");
    a_stream_opposite: assert property (k_rise && mode_now == MODE_STREAM
        && !ctl_i.proc_input_enable_n |=> sys_data_lines_o == $past(proc_data_lines_i))
        else $error("stream word missing from opposite latch");
    a_write_one_port: assert property (mem_we |-> (ctl_i.proc_input_enable_n
        ^ ctl_i.sys_input_enable_n) && !ctl_i.write_n && sel_reg)
        else $error("write without exactly one input enable");
    a_check_bus_word: assert property (k_rise && bus_valid && ctrl_reg[CTRL_CHECK_EN]
        |=> pend_reg == !(^$past(bus_now)))
        else $error("parity check not taken from the bus word");
    a_read_decode: assert property (k_rise && sel_reg && ctl_i.write_n
        && ctl_i.proc_input_enable_n && ctl_i.sys_input_enable_n
        && !ctl_i.proc_output_enable_n |-> mode_now == MODE_READ)
        else $error("read not decoded with write control high");
    a_latch_holds: assert property (!$past(k_rise) |-> $stable(proc_data_lines_o))
        else $error("processor latch changed away from a rising edge");
    a_write_stream: assert property (mem_we && !ctl_i.proc_input_enable_n
        |=> sys_data_lines_o == $past(proc_data_lines_i))
        else $error("streamed write word differs on the other port");
    a_power_float: assert property (disable iff (1'b0) !rst_b_i |=> proc_data_lines_oe_n_o
        && sys_data_lines_oe_n_o)
        else $error("data port driven during reset");
    a_deselect_float: assert property (k_rise && !sel_reg |=> ##1 proc_data_lines_oe_n_o
        && sys_data_lines_oe_n_o && parity_fault_n_oe_n_o)
        else $error("port driven after deselect");
    a_nowrite_float: assert property (k_rise && sel_reg && !ctl_i.write_n
        && ctl_i.proc_input_enable_n && ctl_i.sys_input_enable_n
        |=> ##1 proc_data_lines_oe_n_o && sys_data_lines_oe_n_o)
        else $error("port driven after write with no input enable");
    a_addr_fall: assert property (k_fall |=> addr_reg == $past(addr_i))
        else $error("address not captured on falling edge");

endmodule : dpsp_top

// file: test/dpsp_ctl_model.sv
// Behavioural model of the processor and system bus controllers facing the memory block.
`timescale 1ns/1ps
module dpsp_ctl_model
    import dpsp_pkg::*;
(
    // Pacing clock.
    input  wire logic        clk_sys_i,
    // Memory clock, address and selects.
    output logic             k_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic             sel_n_o,
    output logic             sel_h_o,
    // Cycle controls and port data.
    output dpsp_ctl_t        ctl_o,
    output dpsp_word_t       pword_o,
    output dpsp_word_t       sword_o
);
    // Idle state: K parked high, all controls inactive, ports carrying a filler.
    initial begin
        k_o     = 1'b1;
        addr_o  = '0;
        sel_n_o = 1'b1;
        sel_h_o = 1'b0;
        ctl_o   = 5'h1F;
        pword_o = 9'h155;
        sword_o = 9'h0AA;
    end

    // One memory cycle; each K phase is kept at least two system clocks long.
    task automatic run_cycle(input logic [ADDR_W-1:0] a, input logic sel, input dpsp_ctl_t c,
                             input dpsp_word_t pw, input dpsp_word_t sw);
        @(posedge clk_sys_i);
        k_o     <= 1'b0;
        addr_o  <= a;
        sel_n_o <= ~sel;
        sel_h_o <= sel;
        repeat (3) @(posedge clk_sys_i);
        ctl_o   <= c;
        pword_o <= pw;
        sword_o <= sw;
        k_o     <= 1'b1;
        // Address and selects move away after the fall, so a late capture is caught.
        @(posedge clk_sys_i);
        addr_o  <= ~a;
        sel_n_o <= sel;
        sel_h_o <= ~sel;
        @(posedge clk_sys_i);
        // Input enables drop and the lines flip once hold has run out.
        ctl_o.write_n             <= 1'b1;
        ctl_o.proc_input_enable_n <= 1'b1;
        ctl_o.sys_input_enable_n  <= 1'b1;
        pword_o <= ~pw;
        sword_o <= ~sw;
        repeat (2) @(posedge clk_sys_i);
    endtask : run_cycle
endmodule : dpsp_ctl_model

// file: test/dpsp_top_tb_top.sv
// Self-checking testbench of the dual-port parity-checked memory block.
`timescale 1ns/1ps
module dpsp_top_tb_top;
    import dpsp_pkg::*;
    logic              clk_sys_i;
    logic              rst_b_i;
    logic              k;
    logic [ADDR_W-1:0] addr;
    logic              sel_n;
    logic              sel_h;
    dpsp_ctl_t         ctl;
    dpsp_word_t        pw_i;
    dpsp_word_t        sw_i;
    dpsp_word_t        pw_o;
    dpsp_word_t        sw_o;
    logic              p_oe_n;
    logic              s_oe_n;
    logic              flt_n;
    logic              flt_oe_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    int                num_errors;
    int                samples_checked;
    logic [31:0]       rd;
    logic              err;
    // Words: good odd parity, bad parity, and a bad word only ever streamed.
    localparam dpsp_word_t W_GOOD = 9'h1A5;
    localparam dpsp_word_t W_BAD  = 9'h03C;
    localparam dpsp_word_t W_STR  = 9'h101;

    dpsp_top DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .k_i(k), .addr_i(addr),
        .select_low_active_n_i(sel_n), .select_high_active_i(sel_h), .ctl_i(ctl),
        .proc_data_lines_i(pw_i), .proc_data_lines_o(pw_o), .proc_data_lines_oe_n_o(p_oe_n),
        .sys_data_lines_i(sw_i), .sys_data_lines_o(sw_o), .sys_data_lines_oe_n_o(s_oe_n),
        .parity_fault_n_o(flt_n), .parity_fault_n_oe_n_o(flt_oe_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));

    dpsp_ctl_model u_ctl (.clk_sys_i(clk_sys_i), .k_o(k), .addr_o(addr), .sel_n_o(sel_n),
        .sel_h_o(sel_h), .ctl_o(ctl), .pword_o(pw_i), .sword_o(sw_i));

    // Clock at 200 MHz.
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Prints the verdict and ends the run; also used by the watchdog.
    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // Compares one value, widened to a word, with case equality.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1);
        chk("apb_wait", 32'h1, n);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Port drive enables and the fault pin after a memory cycle.
    task automatic chk_pins(input logic p, input logic s, input logic f);
        chk("proc_oe_n", {31'h0, p}, {31'h0, p_oe_n});
        chk("sys_oe_n", {31'h0, s}, {31'h0, s_oe_n});
        chk("fault_oe_n", {31'h0, f}, {31'h0, flt_oe_n});
        chk("fault_n", {31'h0, f}, {31'h0, flt_n});
    endtask : chk_pins

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        complete_run();
    end

    // Main sequence.
    initial begin
        num_errors = 0;
        samples_checked = 0;
        rst_b_i = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr  = '0;
        pwdata = '0;
        repeat (5) @(posedge clk_sys_i);
        chk_pins(1'b1, 1'b1, 1'b1);
        rst_b_i <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, REG_MASK, 32'h0);
        chk("mask", 32'h0, rd);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk("unmapped_err", 32'h1, {31'h0, err});
        // Processor write streaming to the system port, then read back.
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b00110, W_GOOD, 9'h000);
        chk("sys_stream", {23'h0, W_GOOD}, {23'h0, sw_o});
        chk_pins(1'b1, 1'b0, 1'b1);
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b11101, 9'h000, 9'h000);
        chk("proc_read", {23'h0, W_GOOD}, {23'h0, pw_o});
        chk_pins(1'b0, 1'b1, 1'b1);
        // System write of a bad-parity word; fault shows one K cycle later.
        u_ctl.run_cycle(15'h0200, 1'b1, 5'b01011, 9'h000, W_BAD);
        u_ctl.run_cycle(15'h0200, 1'b1, 5'b11110, 9'h000, 9'h000);
        chk("sys_read", {23'h0, W_BAD}, {23'h0, sw_o});
        chk_pins(1'b1, 1'b0, 1'b0);
        // Both enables low, then both high: no array access, ports float.
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b00011, W_BAD, W_BAD);
        chk_pins(1'b1, 1'b1, 1'b0);
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b01111, W_BAD, W_BAD);
        chk_pins(1'b1, 1'b1, 1'b1);
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b11101, 9'h000, 9'h000);
        chk("after_nop", {23'h0, W_GOOD}, {23'h0, pw_o});
        chk("after_nop_oe", 32'h0, {31'h0, p_oe_n});
        // Stream without write; the streamed bus word alone is checked.
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b11001, 9'h000, W_STR);
        chk("proc_stream", {23'h0, W_STR}, {23'h0, pw_o});
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b11101, 9'h000, 9'h000);
        chk("stream_fault", 32'h0, {31'h0, flt_oe_n});
        chk("array_kept", {23'h0, W_GOOD}, {23'h0, pw_o});
        // Stream without write from the processor port to the system latch.
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b10110, 9'h0FE, 9'h000);
        chk("sys_stream_nw", 32'h0FE, {23'h0, sw_o});
        chk_pins(1'b1, 1'b0, 1'b1);
        // Deselected cycle: standby with everything released.
        u_ctl.run_cycle(15'h0123, 1'b0, 5'b11101, 9'h000, 9'h000);
        chk_pins(1'b1, 1'b1, 1'b1);
        chk("standby_fault", 32'h1, {31'h0, flt_n});
        // Interrupt: raised only when unmasked, dropped by write-one-to-clear.
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status_ev", 32'h3, rd);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, REG_MASK, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_on", 32'h1, {31'h0, irq});
        chk("pready_idle", 32'h0, {31'h0, pready});
        apb(1'b1, REG_STATUS, 32'h7);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status_clr", 32'h0, rd);
        // Check disabled: a bad streamed word must leave the flag released.
        apb(1'b1, REG_CTRL, 32'h0);
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b11001, 9'h000, W_STR);
        u_ctl.run_cycle(15'h0123, 1'b1, 5'b11101, 9'h000, 9'h000);
        chk("fault_masked", 32'h1, {31'h0, flt_oe_n});
        complete_run();
    end
endmodule : dpsp_top_tb_top
